// File: rtl/radio_addr_pkg.sv
package radio_addr_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_OWN    = 8'h04;
	localparam logic [7:0] OFS_DEST   = 8'h08;
	localparam logic [7:0] OFS_CMD    = 8'h0C;
	localparam logic [7:0] OFS_RX_LO  = 8'h10;
	localparam logic [7:0] OFS_RX_HI  = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_INFO   = 8'h1C;
	// codeword field positions, bit 1 of the codeword is bit 47
	localparam int MC_LO  = 42;
	localparam int CAT_LO = 45;
	localparam int RC_LO  = 36;
	localparam int COM_LO = 24;
	localparam int SRC_LO = 12;
	localparam int DST_LO = 0;
	// address-style register fields (own and destination)
	localparam int ADR_LO = 0;
	localparam int AC_LO  = 12;
	localparam int ARC_LO = 24;
	localparam logic [11:0] UNUSED_ADDR = 12'hFFF;
	// control register fields and reset value
	localparam int CTL_AUTO   = 0;
	localparam int CTL_MANUAL = 1;
	localparam logic [1:0] CTRL_RST = 2'h1;
	// command register fields
	localparam int CMD_EXT = 6;
	// status register bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_RXNEW = 1;
	localparam int ST_UNIMPL = 2;
	localparam int ST_CMDERR = 3;
	localparam int ST_EMRG = 4;
	localparam int ST_CALL = 5;
	localparam int ST_DIS = 6;
	localparam int ST_RPT = 7;
	localparam int ST_CBACK = 8;
	localparam int ST_IDENT = 9;
	localparam int ST_KEY = 10;
	localparam int ST_CHAN = 11;
	localparam int ST_STAT = 12;
	localparam int ST_CANCEL = 13;
	localparam int ST_MANREQ = 14;
	localparam int ST_W = 15;
	// category codes
	localparam logic [2:0] CAT_SYS = 3'h0, CAT_CALL = 3'h1, CAT_ACK = 3'h2, CAT_SPEC = 3'h3;
	localparam logic [2:0] CAT_STAT0 = 3'h4, CAT_STAT1 = 3'h5, CAT_RSVD = 3'h6, CAT_CUST = 3'h7;
	// system function codes
	localparam logic [2:0] F_EMRG_RESET = 3'h0, F_CANCEL = 3'h1, F_CLEAR = 3'h2, F_IDENT = 3'h3;
	localparam logic [2:0] F_KEY_ON = 3'h4, F_KEY_OFF = 3'h5, F_RPT_ON = 3'h6, F_RPT_OFF = 3'h7;
	// call function codes
	localparam logic [2:0] F_EMRG_CALL = 3'h0, F_PHONE = 3'h3, F_CALLBACK = 3'h5;
	localparam logic [2:0] F_MANUAL = 3'h6, F_EXTERN = 3'h7;
	// acknowledgement function codes
	localparam logic [2:0] A_EMRG = 3'h0, A_GENERAL = 3'h2, A_REJECT = 3'h7;
	// special function codes
	localparam logic [2:0] F_CHANNEL = 3'h3, F_ENABLE = 3'h6, F_DISABLE = 3'h7;
	typedef enum logic [1:0] {TX_IDLE, TX_HOLD, TX_RELEASE} tx_state_t;
endpackage

// File: rtl/radio_addr_host.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - every message opens with an address codeword
// - first six bits hold message characteristic
// - next six bits hold binary regional code
// - then common part, transmitter, receiver, twelve each
// - normal mode sends one codeword, 12-bit addresses
// - external mode: transmitter word then receiver word
// - unused address field in external words is FFF
// - characteristic splits into category then function
// - category decode: system, call, ack, special, status
// - never emit codes of unimplemented options; commands refuse the reserved category (other unimplemented codes pass) and writes while one is queued
// - system functions: reset, cancel, clear, id, key, repeater
// - sixteen status values exchanged between stations
module radio_addr_host (
	input  wire logic        MCLK,      // 100 MHz clock
	input  wire logic        RESET,     // async reset, active high
	input  wire logic        PSEL,      // apb select
	input  wire logic        PENABLE,   // apb access phase
	input  wire logic        PWRITE,    // apb write
	input  wire logic [7:0]  PADDR,     // apb byte address
	input  wire logic [31:0] PWDATA,    // apb write data
	output logic      [31:0] PRDATA,    // apb read data
	output logic             PREADY,    // apb ready
	output logic             PSLVERR,   // apb error on unmapped offset
	input  wire logic        RX_VALID,  // received codeword present (level pulse, no acknowledge)
	input  wire logic [47:0] RX_WORD,   // received codeword, stable while valid
	output logic      [47:0] TX_WORD,   // codeword to send
	output logic             TX_VALID,  // codeword offered (4-phase)
	input  wire logic        TX_ACK     // link took the codeword
);
	//////////////////////////////////////////////////////////////////////////
	// decode functions
	function automatic logic is_impl(input logic [2:0] c, input logic [2:0] f);
		unique case (c)
			radio_addr_pkg::CAT_SYS, radio_addr_pkg::CAT_ACK,
			radio_addr_pkg::CAT_STAT0, radio_addr_pkg::CAT_STAT1: is_impl = 1'b1;
			radio_addr_pkg::CAT_CALL: is_impl = (f != radio_addr_pkg::F_PHONE);
			radio_addr_pkg::CAT_SPEC: is_impl = (f == radio_addr_pkg::F_CHANNEL) ||
				(f == radio_addr_pkg::F_ENABLE) || (f == radio_addr_pkg::F_DISABLE);
			radio_addr_pkg::CAT_RSVD, radio_addr_pkg::CAT_CUST: is_impl = 1'b0;
		endcase
	endfunction
	function automatic logic needs_ack(input logic [2:0] c, input logic [2:0] f,
		input logic ok);
		if (!ok)
			needs_ack = 1'b1;
		else if (c == radio_addr_pkg::CAT_ACK)
			needs_ack = 1'b0;
		else if (c == radio_addr_pkg::CAT_SYS)
			needs_ack = !(f == radio_addr_pkg::F_CLEAR || f == radio_addr_pkg::F_IDENT ||
				f == radio_addr_pkg::F_KEY_ON || f == radio_addr_pkg::F_KEY_OFF);
		else
			needs_ack = 1'b1;
	endfunction
	// fields in order: characteristic, region, common, transmitter, receiver
	function automatic logic [47:0] build(input logic [5:0] mc, input logic [5:0] rc,
		input logic [11:0] common_address_part, input logic [11:0] src, input logic [11:0] dst);
		build = {mc, rc, common_address_part, src, dst};
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// declarations
	logic [2:0]  rxs_r, acks_r;          // three-stage pin synchronisers
	logic        rx_lvl_r, rx_prev_r;    // filtered receive level and delay
	logic        ack_lvl_r;              // filtered transmit acknowledge
	logic [47:0] rx_word_r;              // captured codeword
	logic        rx_proc_r;              // one-cycle decode strobe
	logic [1:0]  ctrl_r;                 // auto ack enable, manual reply mode
	logic [29:0] own_r, dest_r;          // region, common, individual address
	logic [6:0]  cmd_r;                  // external flag, category, function
	logic        cmd_pend_r, ack_pend_r; // queued transmissions
	logic [5:0]  ack_mc_r;               // characteristic of queued ack
	logic [11:0] ack_dst_r;              // who the queued ack goes to
	logic [47:0] word_r, second_r;       // codeword on the pins, follow-up
	logic        valid_r, has_second_r;  // offer and second-word pending
	radio_addr_pkg::tx_state_t state_r;  // transmit handshake state
	logic        ext_wait_r;             // first external word seen
	logic [11:0] ext_src_r;              // sender from first external word
	logic [radio_addr_pkg::ST_W-1:0] flags_r; // status bits
	logic [11:0] cback_r, chan_r;        // stored caller, commanded channel
	logic [3:0]  statv_r;                // last status value
	logic [31:0] prdata_r;               // read data
	logic        pready_r, pslverr_r;    // bus answer
	logic        wr_en;                  // committed write
	logic        cmd_wr, cmd_ok;         // command write and its acceptance
	logic [2:0]  category_code, function_code;               // received category and function
	logic [11:0] sender;                 // resolved transmitter address
	logic        ext_first, for_us, act, impl, ack_need;
	logic [radio_addr_pkg::ST_W-1:0] set, clr; // flag set and software clear
	logic        evt_emrg_reset, evt_cancel, evt_clear, evt_call;

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers; a level changes once stages two and three agree
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			rxs_r     <= 3'h0;
			acks_r    <= 3'h0;
			rx_lvl_r  <= 1'b0;
			ack_lvl_r <= 1'b0;
			rx_prev_r <= 1'b0;
		end else begin
			rxs_r     <= {rxs_r[1:0], RX_VALID};
			acks_r    <= {acks_r[1:0], TX_ACK};
			rx_lvl_r  <= (rxs_r[1] == rxs_r[2]) ? rxs_r[2] : rx_lvl_r;
			ack_lvl_r <= (acks_r[1] == acks_r[2]) ? acks_r[2] : ack_lvl_r;
			rx_prev_r <= rx_lvl_r;
		end
	end

	// capture the word on the rising receive level, decode a cycle later
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			rx_word_r <= 48'h0;
			rx_proc_r <= 1'b0;
		end else begin
			rx_proc_r <= rx_lvl_r & ~rx_prev_r;
			if (rx_lvl_r & ~rx_prev_r)
				rx_word_r <= RX_WORD;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// receive decode
	always_comb begin
		category_code = rx_word_r[radio_addr_pkg::CAT_LO+:3];
		function_code = rx_word_r[radio_addr_pkg::MC_LO+:3];
		// external first word: receiver field unused, sender complete
		ext_first = rx_proc_r && !ext_wait_r && category_code == radio_addr_pkg::CAT_CALL &&
			function_code == radio_addr_pkg::F_EXTERN &&
			rx_word_r[radio_addr_pkg::DST_LO+:12] == radio_addr_pkg::UNUSED_ADDR;
		// second external word matches the individual address only
		if (ext_wait_r)
			for_us = rx_word_r[radio_addr_pkg::DST_LO+:12] == own_r[radio_addr_pkg::ADR_LO+:12];
		else
			for_us = rx_word_r[radio_addr_pkg::DST_LO+:12] == own_r[radio_addr_pkg::ADR_LO+:12] &&
				rx_word_r[radio_addr_pkg::COM_LO+:12] == own_r[radio_addr_pkg::AC_LO+:12] &&
				rx_word_r[radio_addr_pkg::RC_LO+:6] == own_r[radio_addr_pkg::ARC_LO+:6];
		sender = ext_wait_r ? ext_src_r : rx_word_r[radio_addr_pkg::SRC_LO+:12];
		act    = rx_proc_r && for_us && !ext_first;
		// a disabled station refuses calls
		impl   = is_impl(category_code, function_code) && !(flags_r[radio_addr_pkg::ST_DIS] &&
			category_code == radio_addr_pkg::CAT_CALL);
		ack_need = act && ctrl_r[radio_addr_pkg::CTL_AUTO] && needs_ack(category_code, function_code, impl) &&
			!(ctrl_r[radio_addr_pkg::CTL_MANUAL] && impl &&
			category_code == radio_addr_pkg::CAT_CALL);
		evt_emrg_reset = act && category_code == radio_addr_pkg::CAT_SYS && function_code == radio_addr_pkg::F_EMRG_RESET;
		evt_cancel = act && category_code == radio_addr_pkg::CAT_SYS && function_code == radio_addr_pkg::F_CANCEL;
		evt_clear  = act && category_code == radio_addr_pkg::CAT_SYS && function_code == radio_addr_pkg::F_CLEAR;
		evt_call   = act && impl && category_code == radio_addr_pkg::CAT_CALL;
	end

	// external sequence tracking; any following word ends the wait
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			ext_wait_r <= 1'b0;
			ext_src_r  <= 12'h0;
		end else if (rx_proc_r) begin
			ext_wait_r <= ext_first;
			if (ext_first)
				ext_src_r <= rx_word_r[radio_addr_pkg::SRC_LO+:12];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// status flags: set wins over a software clear in the same cycle
	always_comb begin
		set = '0;
		clr = '0;
		set[radio_addr_pkg::ST_RXNEW]  = act;
		set[radio_addr_pkg::ST_UNIMPL] = act && !impl;
		set[radio_addr_pkg::ST_CMDERR] = cmd_wr && !cmd_ok;
		set[radio_addr_pkg::ST_EMRG]   = evt_call && function_code == radio_addr_pkg::F_EMRG_CALL;
		set[radio_addr_pkg::ST_CALL]   = evt_call && function_code != radio_addr_pkg::F_CALLBACK;
		set[radio_addr_pkg::ST_CBACK]  = evt_call && function_code == radio_addr_pkg::F_CALLBACK;
		set[radio_addr_pkg::ST_IDENT]  = act && category_code == radio_addr_pkg::CAT_SYS &&
			function_code == radio_addr_pkg::F_IDENT;
		set[radio_addr_pkg::ST_CHAN]   = act && category_code == radio_addr_pkg::CAT_SPEC &&
			function_code == radio_addr_pkg::F_CHANNEL;
		set[radio_addr_pkg::ST_STAT]   = act && (category_code == radio_addr_pkg::CAT_STAT0 ||
			category_code == radio_addr_pkg::CAT_STAT1);
		set[radio_addr_pkg::ST_CANCEL] = evt_cancel;
		set[radio_addr_pkg::ST_MANREQ] = evt_call && ctrl_r[radio_addr_pkg::CTL_MANUAL];
		if (wr_en && PADDR == radio_addr_pkg::OFS_STATUS)
			clr = PWDATA[radio_addr_pkg::ST_W-1:0];
		// emergency reset drops emergency and call, clear down only the call
		clr[radio_addr_pkg::ST_EMRG] = evt_emrg_reset;
		clr[radio_addr_pkg::ST_CALL] = evt_emrg_reset || evt_clear || evt_cancel;
	end

	// sticky and state flags; busy, disabled, repeater and key follow state
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			flags_r <= '0;
		end else begin
			flags_r <= (flags_r & ~clr) | set;
			flags_r[radio_addr_pkg::ST_BUSY] <= cmd_pend_r || ack_pend_r ||
				state_r != radio_addr_pkg::TX_IDLE;
			if (act && category_code == radio_addr_pkg::CAT_SPEC && function_code == radio_addr_pkg::F_DISABLE)
				flags_r[radio_addr_pkg::ST_DIS] <= 1'b1;
			else if (act && category_code == radio_addr_pkg::CAT_SPEC && function_code == radio_addr_pkg::F_ENABLE)
				flags_r[radio_addr_pkg::ST_DIS] <= 1'b0;
			else
				flags_r[radio_addr_pkg::ST_DIS] <= flags_r[radio_addr_pkg::ST_DIS];
			if (act && category_code == radio_addr_pkg::CAT_SYS && function_code[2:1] == 2'h3)
				flags_r[radio_addr_pkg::ST_RPT] <= ~function_code[0];
			else
				flags_r[radio_addr_pkg::ST_RPT] <= flags_r[radio_addr_pkg::ST_RPT];
			if (act && category_code == radio_addr_pkg::CAT_SYS && function_code[2:1] == 2'h2)
				flags_r[radio_addr_pkg::ST_KEY] <= ~function_code[0];
			else
				flags_r[radio_addr_pkg::ST_KEY] <= flags_r[radio_addr_pkg::ST_KEY];
		end
	end

	// captured message data
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			cback_r <= 12'h0;
			chan_r  <= 12'h0;
			statv_r <= 4'h0;
		end else begin
			if (set[radio_addr_pkg::ST_CBACK])
				cback_r <= sender;
			// channel number travels in the common field of the command
			if (set[radio_addr_pkg::ST_CHAN])
				chan_r <= rx_word_r[radio_addr_pkg::COM_LO+:12];
			if (set[radio_addr_pkg::ST_STAT])
				statv_r <= {category_code[0], function_code};
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			ctrl_r <= radio_addr_pkg::CTRL_RST;
			own_r  <= 30'h0;
			dest_r <= 30'h0;
		end else if (wr_en) begin
			if (PADDR == radio_addr_pkg::OFS_CTRL)
				ctrl_r <= PWDATA[1:0];
			if (PADDR == radio_addr_pkg::OFS_OWN)
				own_r <= PWDATA[29:0];
			if (PADDR == radio_addr_pkg::OFS_DEST)
				dest_r <= PWDATA[29:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// transmit queue and 4-phase handshake; acks go before commands
	assign cmd_wr = wr_en && PADDR == radio_addr_pkg::OFS_CMD;
	// reserved category is never sent, one command at a time
	assign cmd_ok = !cmd_pend_r && PWDATA[5:3] != radio_addr_pkg::CAT_RSVD;

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			state_r      <= radio_addr_pkg::TX_IDLE;
			cmd_r        <= 7'h0;
			cmd_pend_r   <= 1'b0;
			ack_pend_r   <= 1'b0;
			ack_mc_r     <= 6'h0;
			ack_dst_r    <= 12'h0;
			word_r       <= 48'h0;
			second_r     <= 48'h0;
			has_second_r <= 1'b0;
			valid_r      <= 1'b0;
		end else begin
			if (cmd_wr && cmd_ok) begin
				cmd_r      <= PWDATA[6:0];
				cmd_pend_r <= 1'b1;
			end
			if (ack_need) begin
				ack_pend_r <= 1'b1;
				ack_dst_r  <= sender;
				if (!impl)
					ack_mc_r <= {radio_addr_pkg::CAT_ACK, radio_addr_pkg::A_REJECT};
				else if (category_code == radio_addr_pkg::CAT_CALL && function_code == radio_addr_pkg::F_EMRG_CALL)
					ack_mc_r <= {radio_addr_pkg::CAT_ACK, radio_addr_pkg::A_EMRG};
				else
					ack_mc_r <= {radio_addr_pkg::CAT_ACK, radio_addr_pkg::A_GENERAL};
			end
			unique case (state_r)
				radio_addr_pkg::TX_IDLE: begin
					if (ack_pend_r && !ack_need) begin
						word_r       <= build(ack_mc_r, own_r[radio_addr_pkg::ARC_LO+:6],
							own_r[radio_addr_pkg::AC_LO+:12],
							own_r[radio_addr_pkg::ADR_LO+:12], ack_dst_r);
						has_second_r <= 1'b0;
						ack_pend_r   <= 1'b0;
						valid_r      <= 1'b1;
						state_r      <= radio_addr_pkg::TX_HOLD;
					end else if (cmd_pend_r && !evt_cancel && !ack_pend_r && !ack_need) begin
						cmd_pend_r <= 1'b0;
						valid_r    <= 1'b1;
						state_r    <= radio_addr_pkg::TX_HOLD;
						if (cmd_r[radio_addr_pkg::CMD_EXT]) begin
							// own address first, receiver field unused
							word_r <= build({radio_addr_pkg::CAT_CALL, radio_addr_pkg::F_EXTERN},
								own_r[radio_addr_pkg::ARC_LO+:6], own_r[radio_addr_pkg::AC_LO+:12],
								own_r[radio_addr_pkg::ADR_LO+:12],
								radio_addr_pkg::UNUSED_ADDR);
							second_r <= build(cmd_r[5:0], dest_r[radio_addr_pkg::ARC_LO+:6],
								dest_r[radio_addr_pkg::AC_LO+:12], radio_addr_pkg::UNUSED_ADDR,
								dest_r[radio_addr_pkg::ADR_LO+:12]);
							has_second_r <= 1'b1;
						end else begin
							// identification also carries own address here
							word_r <= build(cmd_r[5:0], own_r[radio_addr_pkg::ARC_LO+:6],
								own_r[radio_addr_pkg::AC_LO+:12], own_r[radio_addr_pkg::ADR_LO+:12],
								dest_r[radio_addr_pkg::ADR_LO+:12]);
							has_second_r <= 1'b0;
						end
					end
				end
				radio_addr_pkg::TX_HOLD: begin
					if (ack_lvl_r) begin
						valid_r <= 1'b0;
						state_r <= radio_addr_pkg::TX_RELEASE;
					end
				end
				radio_addr_pkg::TX_RELEASE: begin
					if (!ack_lvl_r) begin
						if (has_second_r) begin
							word_r       <= second_r;
							has_second_r <= 1'b0;
							valid_r      <= 1'b1;
							state_r      <= radio_addr_pkg::TX_HOLD;
						end else begin
							state_r <= radio_addr_pkg::TX_IDLE;
						end
					end
				end
			endcase
			// cancel drops the queued command and a pending second word; a queued ack and a word on the pins complete
			if (evt_cancel) begin
				cmd_pend_r   <= 1'b0;
				has_second_r <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, write commits at the ready edge
	assign wr_en = PSEL && PENABLE && PWRITE && pready_r;

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= PSEL && PENABLE && !pready_r;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
			if (PSEL && PENABLE && !pready_r) begin
				unique case (PADDR)
					radio_addr_pkg::OFS_CTRL:   prdata_r <= {30'h0, ctrl_r};
					radio_addr_pkg::OFS_OWN:    prdata_r <= {2'h0, own_r};
					radio_addr_pkg::OFS_DEST:   prdata_r <= {2'h0, dest_r};
					radio_addr_pkg::OFS_CMD:    prdata_r <= {25'h0, cmd_r};
					radio_addr_pkg::OFS_RX_LO:  prdata_r <= rx_word_r[31:0];
					radio_addr_pkg::OFS_RX_HI:  prdata_r <= {16'h0, rx_word_r[47:32]};
					radio_addr_pkg::OFS_STATUS: prdata_r <= {17'h0, flags_r};
					radio_addr_pkg::OFS_INFO:   prdata_r <= {4'h0, statv_r, chan_r, cback_r};
					default:                    pslverr_r <= 1'b1;
				endcase
			end
		end
	end

	assign PRDATA   = prdata_r;
	assign PREADY   = pready_r;
	assign PSLVERR  = pslverr_r;
	assign TX_WORD  = word_r;
	assign TX_VALID = valid_r;
endmodule // radio_addr_host

// File: tb/radio_addr_props.sv
`timescale 1ns/1ps
module radio_addr_props (
	input wire logic        MCLK,     // block clock
	input wire logic        RESET,    // async reset, active high
	input wire logic        PSEL,     // apb select
	input wire logic        PENABLE,  // apb access phase
	input wire logic [7:0]  PADDR,    // apb byte address
	input wire logic [31:0] PRDATA,   // apb read data
	input wire logic        PREADY,   // apb ready
	input wire logic        PSLVERR,  // apb error
	input wire logic [47:0] TX_WORD,  // offered codeword
	input wire logic        TX_VALID, // offer level
	input wire logic        TX_ACK    // far side took it
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);
	//////////////////////////////////////////////////////////////////////////////
	// first cycle of an access phase
	sequence acc_start;
		PSEL && PENABLE && !$past(PENABLE);
	endsequence
	// one wait state, then the answer
	sequence one_wait;
		!PREADY ##1 PREADY;
	endsequence
	// far side has just taken a word
	sequence ack_seen;
		$rose(TX_ACK) && TX_VALID;
	endsequence
	//////////////////////////////////////////////////////////////////////////////
	access_wait_a: assert property (acc_start |-> one_wait)
		else $error("apb answer not after one wait state");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("apb ready held longer than one cycle");
	ready_access_a: assert property (PREADY |-> PSEL && PENABLE)
		else $error("apb ready outside an access");
	idle_data_a: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data not zero between answers");
	slverr_decode_a: assert property (PREADY |-> PSLVERR == (PADDR > 8'h1C || PADDR[1:0] != 2'h0))
		else $error("error flag does not match the address map");
	// word must not move under the far side while it is still reading it
	tx_hold_a: assert property (TX_VALID && !TX_ACK |=> TX_VALID && $stable(TX_WORD))
		else $error("offered word changed before it was taken");
	tx_release_a: assert property (ack_seen |-> ##[1:6] !TX_VALID)
		else $error("offer not withdrawn after the take");
	ext_fill_a: assert property (TX_VALID && TX_WORD[47:42] == 6'h0F |-> TX_WORD[11:0] == 12'hFFF)
		else $error("external first word receiver field not all ones");
	rsvd_never_a: assert property (TX_VALID |-> TX_WORD[47:45] != radio_addr_pkg::CAT_RSVD)
		else $error("reserved category sent");
endmodule // radio_addr_props

bind radio_addr_host radio_addr_props radio_addr_props_inst (.MCLK(MCLK), .RESET(RESET),
	.PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .TX_WORD(TX_WORD), .TX_VALID(TX_VALID), .TX_ACK(TX_ACK));

// File: tb/remote_station.sv
`timescale 1ns/1ps
module remote_station (
	input  wire logic        clk,      // shared clock
	output logic             rx_valid, // word offered to the block
	output logic      [47:0] rx_word,  // offered word, inverted once released
	input  wire logic [47:0] tx_word,  // word from the block
	input  wire logic        tx_valid, // block offers a word
	output logic             tx_ack    // word taken
);
	int          ack_delay = 1; // cycles before taking, raised for slow runs
	logic [47:0] got[$];        // words taken, oldest first
	initial begin
		rx_valid = 1'b0;
		rx_word = 48'hFFFF_FFFF_FFFF;
		tx_ack = 1'b0;
	end
	// one address codeword per pulse, held past the block's input filter
	task automatic send_word(input logic [47:0] w);
		rx_word <= w;
		rx_valid <= 1'b1;
		repeat (6) @(posedge clk);
		rx_valid <= 1'b0;
		rx_word <= ~w; // released: never leave a stale word showing
		repeat (6) @(posedge clk);
	endtask
	// take each offer whole, external pairs arrive as two offers
	always @(posedge clk) begin
		if (tx_valid && !tx_ack) begin
			got.push_back(tx_word);
			repeat (ack_delay) @(posedge clk);
			tx_ack <= 1'b1;
			while (tx_valid) @(posedge clk);
			tx_ack <= 1'b0;
		end
	end
endmodule // remote_station

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam logic [5:0]  own_rc = 6'h15;    // own region
	localparam logic [11:0] own_com = 12'hA5C; // own common part
	localparam logic [11:0] own_adr = 12'h123; // own address
	localparam logic [5:0]  dst_rc = 6'h2A;    // far region
	localparam logic [11:0] dst_com = 12'h3C1; // far common part
	localparam logic [11:0] dst_adr = 12'h456; // far address
	localparam logic [11:0] snd = 12'h789;     // remote sender
	localparam logic [5:0]  noack = 6'h00;     // no answer expected
	logic        mclk = 1'b0;                  // bench clock
	logic        reset = 1'b1;                 // held 16 cycles
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb strobes
	logic [7:0]  paddr = 8'h00;                // apb address
	logic [31:0] pwdata = 32'h0, prdata, rd;   // bus data, last read
	logic        pready, pslverr, err;         // answer, last error
	logic        rx_valid, tx_valid, tx_ack;   // link handshakes
	logic [47:0] rx_word, tx_word;             // link words
	int          n_mismatch = 0;               // mismatches
	int          total_checks = 0;             // comparisons
	radio_addr_host radio_addr_host_inst (.MCLK(mclk), .RESET(reset), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .RX_VALID(rx_valid), .RX_WORD(rx_word),
		.TX_WORD(tx_word), .TX_VALID(tx_valid), .TX_ACK(tx_ack));
	remote_station remote_station_inst (.clk(mclk), .rx_valid(rx_valid), .rx_word(rx_word),
		.tx_word(tx_word), .tx_valid(tx_valid), .tx_ack(tx_ack));
	always #5 mclk = ~mclk;
	//////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one apb transfer; idles a cycle after so strobes never toggle twice in a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wait_got(input int target, input int lim);
		for (int n = 0; n < lim && remote_station_inst.got.size() < target; n++)
			@(posedge mclk);
	endtask
	// remote word to us, then answer word and one status flag
	task automatic rx_case(input logic [5:0] mc, input int b, input logic v, input logic [5:0] ack);
		int n0;
		n0 = remote_station_inst.got.size();
		remote_station_inst.send_word({mc, own_rc, own_com, snd, own_adr});
		wait_got(n0 + 1, 40);
		check("ack count", 48'(remote_station_inst.got.size() - n0), 48'(ack != noack));
		if (ack != noack)
			check("ack word", remote_station_inst.got[n0], {ack, own_rc, own_com, own_adr, snd});
		apb(1'b0, radio_addr_pkg::OFS_STATUS, 32'h0);
		check("status bit", 48'(rd[b]), 48'(v));
		apb(1'b1, radio_addr_pkg::OFS_STATUS, 32'h0000_FFFF);
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		apb(1'b0, radio_addr_pkg::OFS_CTRL, 32'h0);
		check("ctrl reset", 48'(rd), 48'h1);
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped", 48'({err, rd}), 48'h1_0000_0000);
		apb(1'b1, radio_addr_pkg::OFS_OWN, {2'h0, own_rc, own_com, own_adr});
		apb(1'b0, radio_addr_pkg::OFS_OWN, 32'h0);
		check("own readback", 48'(rd), 48'({own_rc, own_com, own_adr}));
		$display("test regs done");
	endtask
	task automatic t_tx();
		apb(1'b1, radio_addr_pkg::OFS_DEST, {2'h0, dst_rc, dst_com, dst_adr});
		apb(1'b1, radio_addr_pkg::OFS_CMD, 32'h0000_0030);
		apb(1'b0, radio_addr_pkg::OFS_STATUS, 32'h0);
		check("reserved refused", 48'(rd[3]), 48'h1);
		apb(1'b1, radio_addr_pkg::OFS_CMD, 32'h0000_000A);
		wait_got(1, 60);
		check("normal word", remote_station_inst.got[0], {6'h0A, own_rc, own_com, own_adr, dst_adr});
		remote_station_inst.ack_delay = 8;
		apb(1'b1, radio_addr_pkg::OFS_CMD, 32'h0000_004A);
		wait_got(3, 200);
		check("ext first", remote_station_inst.got[1], {6'h0F, own_rc, own_com, own_adr, 12'hFFF});
		check("ext second", remote_station_inst.got[2], {6'h0A, dst_rc, dst_com, 12'hFFF, dst_adr});
		remote_station_inst.ack_delay = 1;
		$display("test tx done");
	endtask
	task automatic t_sys();
		rx_case(6'h08, 4, 1'b1, 6'h10);
		rx_case(6'h00, 4, 1'b0, 6'h12);
		rx_case(6'h01, 13, 1'b1, 6'h12);
		rx_case(6'h0A, 5, 1'b1, 6'h12);
		rx_case(6'h02, 5, 1'b0, noack);
		rx_case(6'h03, 9, 1'b1, noack);
		rx_case(6'h04, 10, 1'b1, noack);
		rx_case(6'h05, 10, 1'b0, noack);
		rx_case(6'h06, 7, 1'b1, 6'h12);
		rx_case(6'h07, 7, 1'b0, 6'h12);
		$display("test system done");
	endtask
	task automatic t_spec();
		rx_case(6'h0D, 8, 1'b1, 6'h12);
		rx_case(6'h1B, 11, 1'b1, 6'h12);
		rx_case(6'h2F, 12, 1'b1, 6'h12);
		apb(1'b0, radio_addr_pkg::OFS_INFO, 32'h0);
		check("info", 48'(rd), 48'({4'hF, own_com, snd}));
		rx_case(6'h1F, 6, 1'b1, 6'h12);
		rx_case(6'h0A, 2, 1'b1, 6'h17);
		rx_case(6'h1E, 6, 1'b0, 6'h12);
		rx_case(6'h30, 2, 1'b1, 6'h17);
		rx_case(6'h38, 2, 1'b1, 6'h17);
		rx_case(6'h12, 1, 1'b1, noack);
		apb(1'b1, radio_addr_pkg::OFS_CTRL, 32'h0000_0003);
		rx_case(6'h0A, 14, 1'b1, noack);
		apb(1'b1, radio_addr_pkg::OFS_CTRL, 32'h0000_0001);
		$display("test special done");
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_regs();
		t_tx();
		t_sys();
		t_spec();
		tally_and_finish();
	end
endmodule // tb_top
